// [tb_top.sv]
// self-checking bench for the timer/counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    import tmz_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic watchdog_clear_instr = 1'b0;
    logic [31:0] prdata, v;
    logic pready, pslverr, external_count_input, wdt_prescale_pulse, irq, err;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int wdt_n = 0;
    always #20 pclk = ~pclk;
    tmz_timer tmz_timer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .external_count_input, .watchdog_clear_instr, .wdt_prescale_pulse, .irq);
    tmz_pin_src tmz_pin_src_i (.pclk, .external_count_input);
    task end_sim;
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (wdt_prescale_pulse === 1'b1) wdt_n++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim;
        end
    end
    // waits as long as the slave takes; only the cycle ceiling ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] e, input string n);
        xfer(1'b0, a, 8'h00);
        `CHK(n, e, v[7:0])
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(TMZ_OPTION_OFS, TMZ_OPTION_RST, "opt_rst");
        rc(TMZ_COUNT_OFS, TMZ_COUNT_RST, "cnt_rst");
        xfer(1'b1, 12'h020, 8'h5a);
        `CHK("slverr", 1'b1, err)
        rc(12'h020, 8'h00, "unmapped");
        xfer(1'b1, TMZ_OPTION_OFS, 8'h08);
        xfer(1'b1, TMZ_COUNT_OFS, 8'h10);
        rc(TMZ_COUNT_OFS, 8'h10, "holdoff");
        wdt_n = 0;
        watchdog_clear_instr <= 1'b1;
        @(posedge pclk);
        watchdog_clear_instr <= 1'b0;
        repeat (159) @(posedge pclk);
        `CHK("wdt_ticks", 1'b1, wdt_n inside {[19:21]})
        xfer(1'b0, TMZ_COUNT_OFS, 8'h00);
        `CHK("rate_1to1", 1'b1, v[7:0] inside {[8'h35:8'h3a]})
        xfer(1'b1, TMZ_COUNT_OFS, 8'hfe);
        repeat (40) @(posedge pclk);
        rc(TMZ_STATUS_OFS, 8'h01, "ovf_flag");
        `CHK("irq_masked", 1'b0, irq)
        repeat (40) @(posedge pclk);
        rc(TMZ_STATUS_OFS, 8'h01, "ovf_sticky");
        xfer(1'b1, TMZ_MASK_OFS, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("irq_on", 1'b1, irq)
        xfer(1'b1, TMZ_STATUS_OFS, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK("irq_off", 1'b0, irq)
        rc(TMZ_STATUS_OFS, 8'h00, "ovf_clr");
        xfer(1'b1, TMZ_CTRL_OFS, 8'h02);
        // four ratio periods after a prescaler-clearing count write give exactly four increments
        for (int p = 0; p < 8; p++) begin
            xfer(1'b1, TMZ_OPTION_OFS, 8'(p));
            xfer(1'b1, TMZ_COUNT_OFS, 8'h00);
            repeat (16 << (p + 1)) @(posedge pclk);
            xfer(1'b0, TMZ_COUNT_OFS, 8'h00);
            `CHK("ratio", 8'h04, v[7:0])
        end
        xfer(1'b1, TMZ_CTRL_OFS, 8'h02);
        xfer(1'b1, TMZ_COUNT_OFS, 8'h00);
        xfer(1'b1, TMZ_OPTION_OFS, 8'h28);
        xfer(1'b1, TMZ_CTRL_OFS, 8'h02);
        repeat (12) @(posedge pclk);
        tmz_pin_src_i.pulses(5);
        rc(TMZ_COUNT_OFS, 8'h05, "rise_cnt");
        tmz_pin_src_i.set(1'b1);
        rc(TMZ_COUNT_OFS, 8'h06, "rise_edge");
        xfer(1'b1, TMZ_OPTION_OFS, 8'h38);
        xfer(1'b1, TMZ_COUNT_OFS, 8'h00);
        repeat (12) @(posedge pclk);
        tmz_pin_src_i.set(1'b0);
        rc(TMZ_COUNT_OFS, 8'h01, "fall_edge");
        tmz_pin_src_i.set(1'b1);
        rc(TMZ_COUNT_OFS, 8'h01, "fall_only");
        xfer(1'b1, TMZ_OPTION_OFS, 8'h08);
        xfer(1'b1, TMZ_CTRL_OFS, 8'h01);
        xfer(1'b1, TMZ_COUNT_OFS, 8'h20);
        repeat (80) @(posedge pclk);
        rc(TMZ_COUNT_OFS, 8'h20, "sleep");
        xfer(1'b1, TMZ_CTRL_OFS, 8'h00);
        end_sim;
    end
endmodule

// [tmz_pin_src.sv]
// external count pulse source driving the count pin
`timescale 1ns/1ps
module tmz_pin_src (
    // clock
    input wire logic pclk,
    // pin
    output logic external_count_input
);
    initial external_count_input = 1'b0;
    // each level lasts at least 9 pclk so sync and edge detect never miss one
    task automatic set(input logic lvl);
        @(posedge pclk);
        external_count_input <= lvl;
        repeat (8) @(posedge pclk);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            set(1'b1);
            set(1'b0);
        end
    endtask
endmodule

// [tmz_pkg.sv]
// package for the 8-bit timer/counter with shared prescaler
package tmz_pkg;
    // apb word offsets (byte addresses)
    localparam logic [11:0] TMZ_OPTION_OFS = 12'h000;
    localparam logic [11:0] TMZ_COUNT_OFS = 12'h004;
    localparam logic [11:0] TMZ_STATUS_OFS = 12'h008;
    localparam logic [11:0] TMZ_MASK_OFS = 12'h00c;
    localparam logic [11:0] TMZ_CTRL_OFS = 12'h010;
    // option field positions
    localparam int TMZ_CSS_BIT = 5;
    localparam int TMZ_SES_BIT = 4;
    localparam int TMZ_PSA_BIT = 3;
    localparam int TMZ_PS_LSB = 0;
    // control register bit positions
    localparam int TMZ_CTRL_SLEEP_BIT = 0;
    localparam int TMZ_CTRL_WDCLR_BIT = 1;
    // reset values
    localparam logic [7:0] TMZ_OPTION_RST = 8'hff;
    localparam logic [7:0] TMZ_COUNT_RST = 8'h00;
    localparam logic [7:0] TMZ_MASK_RST = 8'h00;
    // timing counts: hold-off in instruction cycles, phase clocks per instruction cycle
    localparam int TMZ_WRITE_HOLDOFF = 2;
    localparam int TMZ_PHASES = 4;
endpackage

// [tmz_prescaler.sv]
// 8-bit prescaler shared by the timer and the watchdog
`timescale 1ns/1ps
module tmz_prescaler
    import tmz_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clr,
    input wire logic tick,
    input wire logic [2:0] ratio,
    // output
    output logic pulse
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } tmz_pre_t;
    tmz_pre_t st_reg, st_next;
    logic [WIDTH-1:0] sum;
    logic [WIDTH-1:0] lim;
    initial begin
        if (WIDTH != 8) $error("prescaler width must be 8");
    end
    always_comb begin
        st_next = st_reg;
        // ratio 2^(field+1): the last count before wrap
        lim = WIDTH'((16'h0002 << ratio) - 16'h0001);
        sum = st_reg.cnt + WIDTH'(1);
        pulse = 1'b0;
        if (clr) begin
            st_next.cnt = '0;
        end else if (tick) begin
            pulse = (st_reg.cnt == lim);
            st_next.cnt = pulse ? '0 : sum;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

// [tmz_sync.sv]
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module tmz_sync
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } tmz_sync_t;
    tmz_sync_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign dout = st_reg.s2;
endmodule

// [tmz_timer.sv]
// top: 8-bit timer/counter with shared prescaler, apb registers and interrupt
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tmz_timer
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external count pin and watchdog side
    input wire logic external_count_input,
    input wire logic watchdog_clear_instr,
    output logic wdt_prescale_pulse,
    // interrupt
    output logic irq
);
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } tmz_phase_t;

    typedef struct packed {
        // phase and software-visible registers
        tmz_phase_t phase;
        logic [7:0] option;
        logic [7:0] timer_count;
        logic overflow_flag;
        logic overflow_irq_enable;
        logic sleep;
        // count path and pin edge state
        logic [1:0] holdoff;
        logic ext_prev;
        logic ext_samp;
        logic pend_inc;
        // registered bus answer and outputs
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic wdt_pulse;
    } tmz_top_t;

    tmz_top_t st_reg, st_next;

    // pin and prescaler links
    logic ext_sync;
    logic pre_clr;
    logic pre_tick;
    logic pre_pulse;
    // option fields
    logic css;
    logic ses;
    logic prescaler_assign;
    // cycle and bus decode
    logic ext_edge;
    logic cyc_end;
    logic acc;
    logic wr;
    logic rd;
    logic cnt_wr;
    logic wd_clr;
    // count path
    logic inc_src;
    logic inc;
    logic hit;

    // the one-hot phase code and the two-bit hold-off counter are sized for these counts
    initial begin
        if ($bits(tmz_phase_t) != TMZ_PHASES) begin
            $error("phase code width must equal the phase count");
        end
        if (TMZ_WRITE_HOLDOFF < 1 || TMZ_WRITE_HOLDOFF > 3) begin
            $error("write hold-off must fit the two-bit counter");
        end
    end

    tmz_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(external_count_input),
        .dout(ext_sync)
    );

    tmz_prescaler #(.WIDTH(8)) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .clr(pre_clr),
        .tick(pre_tick),
        .ratio(st_reg.option[TMZ_PS_LSB +: 3]),
        .pulse(pre_pulse)
    );

    always_comb begin
        st_next = st_reg;
        css = st_reg.option[TMZ_CSS_BIT];
        ses = st_reg.option[TMZ_SES_BIT];
        prescaler_assign = st_reg.option[TMZ_PSA_BIT];
        // one wait state: the access edge answers, the next edge shows pready and frees the master
        acc = psel && penable && !st_reg.pready;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        cyc_end = (st_reg.phase == PH_Q4);
        cnt_wr = wr && (paddr == TMZ_COUNT_OFS);
        wd_clr = watchdog_clear_instr || (wr && (paddr == TMZ_CTRL_OFS) && pwdata[TMZ_CTRL_WDCLR_BIT]);
        // edge chosen by select bit: 0 rising, 1 falling
        ext_edge = ses ? (st_reg.ext_prev && !ext_sync) : (!st_reg.ext_prev && ext_sync);

        // four phase clocks make one instruction cycle
        case (st_reg.phase)
            PH_Q1: begin
                st_next.phase = PH_Q2;
            end
            PH_Q2: begin
                st_next.phase = PH_Q3;
            end
            PH_Q3: begin
                st_next.phase = PH_Q4;
            end
            PH_Q4: begin
                st_next.phase = PH_Q1;
            end
            default: begin
                // an illegal code falls back to the first phase
                st_next.phase = PH_Q1;
            end
        endcase

        st_next.ext_prev = ext_sync;
        if (ext_edge) begin
            st_next.ext_samp = 1'b1;
        end

        // prescaler input: timer source when assigned to timer, else cycle ticks for watchdog
        pre_clr = (cnt_wr && !prescaler_assign) || (wd_clr && prescaler_assign);
        if (prescaler_assign) begin
            // sleep freezes only the timer; the watchdog keeps its prescaled tick
            pre_tick = cyc_end;
        end else if (css) begin
            pre_tick = st_reg.ext_samp && !st_reg.sleep;
        end else begin
            pre_tick = cyc_end && !st_reg.sleep;
        end
        if (css && !prescaler_assign && pre_tick) begin
            st_next.ext_samp = ext_edge;
        end

        // source reaching the count before synchronisation
        if (prescaler_assign) begin
            inc_src = css ? st_reg.ext_samp : cyc_end;
            if (css && !st_reg.sleep) begin
                st_next.ext_samp = ext_edge;
            end
        end else begin
            inc_src = pre_pulse;
        end

        // an edge seen while asleep must not count after wake-up
        if (st_reg.sleep) begin
            st_next.ext_samp = 1'b0;
        end

        // latch then apply on q2 or q4 phase
        if (inc_src && !st_reg.sleep) begin
            st_next.pend_inc = 1'b1;
        end
        inc = 1'b0;
        if ((st_reg.phase == PH_Q2 || st_reg.phase == PH_Q4) && st_reg.pend_inc) begin
            inc = !st_reg.sleep && (st_reg.holdoff == 2'd0);
            st_next.pend_inc = inc_src && !st_reg.sleep;
        end
        // a blocked increment is dropped, not deferred past the hold-off
        if (cyc_end && st_reg.holdoff != 2'd0) begin
            st_next.holdoff = st_reg.holdoff - 2'd1;
        end

        hit = inc && (st_reg.timer_count == 8'hff);
        if (inc) begin
            st_next.timer_count = st_reg.timer_count + 8'h01;
        end

        // apb writes
        st_next.pready = acc;
        st_next.pslverr = 1'b0;
        if (acc) begin
            case (paddr)
                TMZ_OPTION_OFS: begin
                    if (wr) begin
                        st_next.option = pwdata[7:0];
                    end
                end
                TMZ_COUNT_OFS: begin
                    if (wr) begin
                        st_next.timer_count = pwdata[7:0];
                        st_next.holdoff = 2'(TMZ_WRITE_HOLDOFF);
                        st_next.pend_inc = 1'b0;
                        hit = 1'b0;
                    end
                end
                TMZ_STATUS_OFS: begin
                    if (wr && pwdata[0]) begin
                        st_next.overflow_flag = 1'b0;
                    end
                end
                TMZ_MASK_OFS: begin
                    if (wr) begin
                        st_next.overflow_irq_enable = pwdata[0];
                    end
                end
                TMZ_CTRL_OFS: begin
                    if (wr) begin
                        st_next.sleep = pwdata[TMZ_CTRL_SLEEP_BIT];
                    end
                end
                default: begin
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        // set after clear so the wrap wins
        if (hit) begin
            st_next.overflow_flag = 1'b1;
        end

        // read data stands only in the answer cycle, zero otherwise
        st_next.prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                TMZ_OPTION_OFS: begin
                    st_next.prdata = {24'h00_0000, st_reg.option};
                end
                TMZ_COUNT_OFS: begin
                    st_next.prdata = {24'h00_0000, st_reg.timer_count};
                end
                TMZ_STATUS_OFS: begin
                    st_next.prdata = {31'h0000_0000, st_reg.overflow_flag};
                end
                TMZ_MASK_OFS: begin
                    st_next.prdata = {31'h0000_0000, st_reg.overflow_irq_enable};
                end
                TMZ_CTRL_OFS: begin
                    st_next.prdata = {31'h0000_0000, st_reg.sleep};
                end
                default: begin
                    st_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // irq follows the next state so it moves on the same edge as flag and enable
        st_next.irq = st_next.overflow_flag && st_next.overflow_irq_enable;
        st_next.wdt_pulse = prescaler_assign ? pre_pulse : cyc_end;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.phase <= PH_Q1;
            st_reg.option <= TMZ_OPTION_RST;
            st_reg.timer_count <= TMZ_COUNT_RST;
            st_reg.overflow_irq_enable <= TMZ_MASK_RST[0];
        end else begin
            st_reg <= st_next;
        end
    end

    // every output is a state flip-flop; nothing combinational reaches a pin
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;
    assign wdt_prescale_pulse = st_reg.wdt_pulse;
endmodule

// [tmz_timer_checker.sv]
// bus and interrupt checker for the timer/counter
`timescale 1ns/1ps
module tmz_timer_checker
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin, watchdog and interrupt
    input wire logic external_count_input,
    input wire logic watchdog_clear_instr,
    input wire logic wdt_prescale_pulse,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mask_q;
    wire wr_mask = psel && penable && pwrite && !pready && paddr == TMZ_MASK_OFS;
    // shadow enable, taken on the same access edge as the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mask_q <= 1'b0;
        else if (wr_mask) mask_q <= pwdata[0];
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_bad_addr;
        s_access ##0 paddr > TMZ_CTRL_OFS;
    endsequence
    a_one_wait: assert property (s_access |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_bad_addr_err: assert property (s_bad_addr |=> pslverr && prdata == 32'h0) else $error("no slave error");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_irq_needs_en: assert property (!mask_q && !$past(mask_q) |-> !irq)
        else $error("irq while disabled");
    a_irq_rise_en: assert property ($rose(irq) |-> mask_q) else $error("irq rose unmasked");
    a_irq_fall_wr: assert property ($fell(irq) |-> $past(pwrite && penable) ||
        $past(pwrite && penable, 2) || $past(pwrite && penable, 3)) else $error("irq fell alone");
    a_wdt_spacing: assert property (wdt_prescale_pulse |=> !wdt_prescale_pulse [*3])
        else $error("watchdog ticks too close");
endmodule

bind tmz_timer tmz_timer_checker tmz_timer_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_count_input, .watchdog_clear_instr,
    .wdt_prescale_pulse, .irq);
